/* File: pkg/afd_consts.vh */
// Purpose: Constants of the averaging filter with distributed read.
// Assumes: 10 MHz system clock; times below are in nanoseconds.
// Notes:   Included by logic/afd_filter.v only.
//
// What this block does
// - Cycle with 1 to 19 shift-clock rises does not reload the output register.
// - A read starts at first shift-clock rise; host ends it before another.
// - Accumulator clears when a read starts, beginning a fresh average.
// - Every conversion completed after clearing is summed until the next read start.
// - Cycle with zero or over 19 rises ends the read; output reloads.
// - During a read the held result shifts out over many cycles unaltered.
// - A zero-edge cycle ends the read at that closing conversion's completion.
// - Output code is the sum of N 24-bit results divided by M.
// - M is the smallest power of two not below N, N up to 65536.
// - M stops at 65536; further results still add, ratio exceeds one.
// - Past the weighting limit output clamps at full scale, never wraps.
// - A 16-bit count N-1, saturating, follows the result MSB first.
// - Busy stays high during conversion; its fall marks completion.
// - With N/M below one the scaled sum is not clamped at N/M.
`ifndef AFD_CONSTS_VH
`define AFD_CONSTS_VH

`define AFD_CLK_PERIOD_NS 100
`define AFD_CONV_TIME_NS  675
`define AFD_CONV_CYC      ((`AFD_CONV_TIME_NS / `AFD_CLK_PERIOD_NS) < 1 ? 1 : \
                           (`AFD_CONV_TIME_NS / `AFD_CLK_PERIOD_NS))
`define AFD_SCK_LIMIT     5'h14
`define AFD_RES_W         24
`define AFD_CNT_W         16
`define AFD_WORD_W        40
`define AFD_MAX_SHIFT     5'h10
`define AFD_RES_MSB       39
`define AFD_CNT_LSB       0

`endif

/* File: logic/afd_filter.v */
// Purpose: Block-averaging filter, output register and serial shifter.
// Assumes: cnv and sck are pins, synchronised here; conv_sample comes
//          from the converter core on clk_sys and is valid at busy fall.
// Notes:   Data on sdo advances after each sensed sck rise.
`timescale 1ns/10ps
`include "afd_consts.vh"

module afd_filter #(
  parameter ACC_W  = 48,
  parameter CONV_CYC = `AFD_CONV_CYC
) (
  input  wire                   clk_sys,
  input  wire                   rst_b,
  input  wire                   cnv,
  input  wire                   sck,
  input  wire [`AFD_RES_W-1:0]  conv_sample,
  output wire                   busy,
  output wire                   sdo,
  output wire                   reading
);

  // Ceiling log2 of N, capped at 16: the shift standing for M
  function [4:0] afd_shift;
    input [16:0] n;
    integer i;
    begin
      afd_shift = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        if (n > (17'h00001 << i))
          afd_shift = i[4:0] + 5'h01;
      end
    end
  endfunction

  reg [1:0]             cnv_sync_reg;
  reg [1:0]             sck_sync_reg;
  reg                   cnv_last_reg;
  reg                   sck_last_reg;
  reg                   busy_reg;
  reg [7:0]             conv_cnt_reg;
  reg [4:0]             edge_cnt_reg;
  reg                   reading_reg;
  reg [ACC_W-1:0]       acc_reg;
  reg [16:0]            n_reg;
  reg [`AFD_WORD_W-1:0] shift_reg;

  reg [ACC_W-1:0]       acc_next;
  reg [16:0]            n_next;
  reg [ACC_W-1:0]       scaled;
  reg [`AFD_RES_W-1:0]  code;
  reg [`AFD_CNT_W-1:0]  count;
  reg                   update;

  wire cnv_rise  = cnv_sync_reg[1] & ~cnv_last_reg;
  wire sck_rise  = sck_sync_reg[1] & ~sck_last_reg;
  wire conv_end  = busy_reg && (conv_cnt_reg == 8'h01);
  wire read_init = sck_rise & ~reading_reg;

  localparam [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
  localparam [ACC_W-1:0] FS_POS  = {{(ACC_W-`AFD_RES_W+1){1'b0}}, {(`AFD_RES_W-1){1'b1}}};
  localparam [ACC_W-1:0] FS_NEG  = {{(ACC_W-`AFD_RES_W+1){1'b1}}, {(`AFD_RES_W-1){1'b0}}};

  // Pins pass two flops; first stage feeds only the second
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnv_sync_reg <= 2'h0;
      sck_sync_reg <= 2'h0;
      cnv_last_reg <= 1'b0;
      sck_last_reg <= 1'b0;
    end else begin
      cnv_sync_reg <= {cnv_sync_reg[0], cnv};
      sck_sync_reg <= {sck_sync_reg[0], sck};
      cnv_last_reg <= cnv_sync_reg[1];
      sck_last_reg <= sck_sync_reg[1];
    end
  end

  // Conversion timer; cnv edges during a conversion are ignored
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg     <= 1'b0;
      conv_cnt_reg <= 8'h00;
    end else if (cnv_rise && !busy_reg) begin
      busy_reg     <= 1'b1;
      conv_cnt_reg <= CONV_CYC[7:0];
    end else if (busy_reg) begin
      conv_cnt_reg <= conv_cnt_reg - 8'h01;
      if (conv_end)
        busy_reg <= 1'b0;
    end
  end

  // Saturating sum with new sample, scaling and clamping
  always @* begin
    acc_next = acc_reg + {{(ACC_W-`AFD_RES_W){conv_sample[`AFD_RES_W-1]}}, conv_sample};
    // Keep the sum from wrapping on very long averages
    if (!acc_reg[ACC_W-1] && !conv_sample[`AFD_RES_W-1] && acc_next[ACC_W-1])
      acc_next = ACC_MAX;
    else if (acc_reg[ACC_W-1] && conv_sample[`AFD_RES_W-1] && !acc_next[ACC_W-1])
      acc_next = ACC_MIN;
    n_next = (n_reg == 17'h1ffff) ? n_reg : n_reg + 17'h00001;
    // Divide by M, the next power of two, capped at 65536
    scaled = $signed(acc_next) >>> afd_shift(n_next);
    // Clamp only when beyond the code range; N/M<1 never hits it
    if ($signed(scaled) > $signed(FS_POS))
      code = FS_POS[`AFD_RES_W-1:0];
    else if ($signed(scaled) < $signed(FS_NEG))
      code = FS_NEG[`AFD_RES_W-1:0];
    else
      code = scaled[`AFD_RES_W-1:0];
    if (n_next > 17'h0ffff)
      count = 16'hffff;
    else
      count = n_next[15:0] - 16'h0001;
    // Zero edges or at least 20 close the cycle with a reload
    update = (edge_cnt_reg == 5'h00) || (edge_cnt_reg >= `AFD_SCK_LIMIT);
  end

  // Edge counter per conversion cycle, judged at busy fall
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_reg <= 5'h00;
    end else if (conv_end) begin
      edge_cnt_reg <= sck_rise ? 5'h01 : 5'h00;
    end else if (sck_rise && edge_cnt_reg < `AFD_SCK_LIMIT) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  // Read state and accumulator
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reading_reg <= 1'b0;
      acc_reg     <= {ACC_W{1'b0}};
      n_reg       <= 17'h00000;
    end else begin
      if (conv_end && update)
        reading_reg <= 1'b0;
      if (read_init)
        reading_reg <= 1'b1;
      // Read start wins: a sample finishing the same cycle is dropped
      if (read_init) begin
        acc_reg <= {ACC_W{1'b0}};
        n_reg   <= 17'h00000;
      end else if (conv_end) begin
        acc_reg <= acc_next;
        n_reg   <= n_next;
      end
    end
  end

  // Output register: reload only on closing cycles, else shift
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= {`AFD_WORD_W{1'b0}};
    end else if (conv_end && update) begin
      shift_reg <= {code, count};
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[`AFD_WORD_W-2:0], 1'b0};
    end
  end

  assign busy    = busy_reg;
  assign sdo     = shift_reg[`AFD_RES_MSB];
  assign reading = reading_reg;

endmodule // afd_filter

/* File: tb/afd_filter_assertions.sv */
// Purpose: Port checks of the averaging filter.
// Assumes: 6-cycle conversion, 2-flop input sync.
// Notes:   Bound to afd_filter below.
`timescale 1ns/10ps
module afd_chk (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        cnv,
  input wire        sck,
  input wire [23:0] conv_sample,
  input wire        busy,
  input wire        sdo,
  input wire        reading
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Conversion timing; strobes during busy must not restart it
  busy_start_a: assert property ($rose(busy) |-> $past(cnv, 3) && $past(cnv, 2)) else $error("no strobe");
  busy_len_a: assert property ($rose(busy) |-> busy[*6] ##1 !busy) else $error("busy length");
  busy_gap_a: assert property ($fell(busy) |-> !busy[*3]) else $error("busy restart");
  // Read framing: starts on a shift rise, ends only at busy fall
  read_start_a: assert property ($rose(reading) |-> $past(sck, 2) || $past(sck, 3)) else $error("read start");
  read_hold_a: assert property ($rose(reading) |=> reading[*2]) else $error("read dropped");
  read_end_a: assert property ($fell(reading) |-> $past(busy) || $past(busy, 2)) else $error("read end");
  mid_conv_a: assert property (busy && $past(busy) |-> !$fell(reading)) else $error("end mid conv");
  // Output bit moves only after a shift rise or a reload
  sdo_move_a: assert property ($changed(sdo) |-> $past(sck) || $past(sck, 2) || $past(busy, 2) || $past(busy, 3))
    else $error("sdo moved");
endmodule // afd_chk
bind afd_filter afd_chk chk_u (.*);

/* File: tb/afd_host.sv */
// Purpose: Host serial controller model.
// Assumes: Shift clock of 800 ns period, idle low.
// Notes:   Captures sdo at each shift rise.
`timescale 1ns/10ps
module afd_host (
  input  wire       clk_sys,
  input  wire       busy,
  input  wire       sdo,
  output reg        cnv,
  output reg        sck
);
  reg [39:0] word = 40'h0;
  initial begin
    cnv = 1'b0;
    sck = 1'b0;
  end
  // One strobe, then n shift clocks after busy falls
  task run(input integer n);
    integer i;
    begin
      @(posedge clk_sys);
      #7 cnv = 1'b1;
      repeat (5) @(posedge clk_sys);
      #7 cnv = 1'b0;
      @(negedge busy);
      #233;
      for (i = 0; i < n; i = i + 1) begin // 1 to 19 pulses per cycle keep the read alive; 0 or 20 and more end it
        word = {word[38:0], sdo};
        sck = 1'b1;
        #400 sck = 1'b0;
        #400;
      end
    end
  endtask
endmodule // afd_host

/* File: tb/averaging_filter_distributed_read_bench.sv */
// Purpose: Self-checking bench of the averaging filter.
// Assumes: 10 MHz clock, host model drives strobes and shifts.
// Notes:   Expected words are {code, count}.
`timescale 1ns/10ps
module averaging_filter_distributed_read_bench;
  reg         clk_sys = 1'b0;
  reg         rst_b = 1'b0;
  reg  [23:0] smp = 24'h0;
  wire        cnv, sck, busy, sdo, reading;
  integer     bad_count = 0;
  integer     check_count = 0;
  integer     ticks = 0;
  always #50 clk_sys = ~clk_sys;
  afd_filter dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cnv(cnv), .sck(sck), .conv_sample(smp),
    .busy(busy), .sdo(sdo), .reading(reading));
  afd_host host_u (.clk_sys(clk_sys), .busy(busy), .sdo(sdo), .cnv(cnv), .sck(sck));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [39:0] seen, input [39:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input [23:0] s, input integer n);
    begin
      @(posedge clk_sys);
      #7 smp = s;
      host_u.run(n);
    end
  endtask
  // Quiet cycles accumulate; a full read clears the sum
  task t_block;
    begin
      cyc(24'h100, 0);
      cyc(24'h200, 0);
      cyc(24'h300, 40);
      chk(host_u.word, {24'h180, 16'h2});
      cyc(24'h400, 40);
      chk(host_u.word, {24'h400, 16'h0});
    end
  endtask
  // Word read 8 bits a cycle; after an idle cycle the read ends at the next busy fall
  task t_dist;
    begin
      cyc(24'ha, 0);
      repeat (5) cyc(24'h10, 8);
      chk(host_u.word, {24'hd, 16'h1});
      cyc(24'h20, 0);
      chk(reading, 1'b1);
      cyc(24'h20, 40);
      chk(host_u.word, {24'h10, 16'h5});
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #7 rst_b = 1'b1;
    t_block;
    t_dist;
    summarize;
  end
  // Hang guard, far above the roughly 1500 cycles needed
  always @(posedge clk_sys) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
endmodule // averaging_filter_distributed_read_bench
